// ==== shared/cih_pkg.sv ====
// constants shared by the core interrupt handler files
package cih_pkg;

  // ************************************************************
  // sources and vectors
  // ************************************************************
  localparam int unsigned   CIH_NUM_SRC     = 15;
  localparam int unsigned   CIH_IDX_W       = 4;
  localparam logic [3:0]    CIH_SRC_EXT0    = 4'h0;
  localparam logic [3:0]    CIH_SRC_EXT1    = 4'h2;
  localparam logic [3:0]    CIH_SRC_KEYPAD  = 4'hb;
  localparam logic [15:0]   CIH_VEC_BASE    = 16'h0003;
  localparam int unsigned   CIH_VEC_SHIFT   = 3;

  // ************************************************************
  // register offsets, reset values and fields
  // ************************************************************
  localparam logic [7:0]    CIH_OFS_EN_A    = 8'ha8;
  localparam logic [7:0]    CIH_OFS_EN_B    = 8'hb1;
  localparam logic [7:0]    CIH_OFS_PL_B    = 8'hb2;
  localparam logic [7:0]    CIH_OFS_PH_B    = 8'hb3;
  localparam logic [7:0]    CIH_OFS_PH_A    = 8'hb7;
  localparam logic [7:0]    CIH_OFS_PL_A    = 8'hb8;
  localparam logic [7:0]    CIH_RST_REG     = 8'h00;
  localparam int unsigned   CIH_BIT_GLOBAL  = 7;
  localparam logic [7:0]    CIH_RD_UNMAPPED = 8'h00;

endpackage

// ==== hw/cih_pin_detect.sv ====
// request detector for one external interrupt input
`timescale 1ns/1ps
`default_nettype none

module cih_pin_detect (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  // request line, already turned active high
  input  wire logic active_i,
  input  wire logic edge_mode_i,
  // set strobe toward the pending flag
  output logic      event_o
);
  logic prev_r;
  logic prev_nxt;

  // previous sample; starts inactive so a line held at reset fires once
  always_comb begin
    prev_nxt = active_i;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  // edge mode fires on the onset, level mode every active cycle
  assign event_o = edge_mode_i ? (active_i & ~prev_r) : active_i;

  edge_onset_a : assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (edge_mode_i && event_o) |-> (active_i && !prev_r && !$past(active_i)))
    else $error("edge event without a fresh onset");

endmodule
`default_nettype wire

// ==== hw/cih_handler.sv ====
// core interrupt handler: flags, enables, priorities, arbitration
`timescale 1ns/1ps
`default_nettype none

module cih_handler (
  // clock and reset
  input  wire logic                             ref_clk_i,
  input  wire logic                             reset_n_i,
  // special-function register byte port
  input  wire logic [7:0]                       sfr_addr_i,
  input  wire logic                             sfr_wr_i,
  input  wire logic                             sfr_rd_i,
  input  wire logic [7:0]                       sfr_wdata_i,
  output logic      [7:0]                       sfr_rdata_o,
  // special-function register bit port
  input  wire logic [7:0]                       bit_addr_i,
  input  wire logic                             bit_wr_i,
  input  wire logic                             bit_rd_i,
  input  wire logic                             bit_wdata_i,
  output logic                                  bit_rdata_o,
  // request sources
  input  wire logic [cih_pkg::CIH_NUM_SRC-1:0]  periph_event_i,
  input  wire logic [cih_pkg::CIH_NUM_SRC-1:0]  flag_clear_i,
  input  wire logic                             ext_request_zero_n_i,
  input  wire logic                             ext_request_one_n_i,
  input  wire logic [1:0]                       ext_edge_mode_i,
  input  wire logic                             keypad_request_in_i,
  // execution unit handshake
  output logic                                  service_req_o,
  output logic      [15:0]                      service_vector_o,
  output logic      [1:0]                       service_level_o,
  input  wire logic                             service_ack_i,
  input  wire logic                             service_return_instr_i,
  // status
  output logic      [cih_pkg::CIH_NUM_SRC-1:0]  pending_o
);
  import cih_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  logic [7:0]             en_a_r, en_a_nxt;
  logic [7:0]             en_b_r, en_b_nxt;
  logic [6:0]             ph_a_r, ph_a_nxt;
  logic [6:0]             pl_a_r, pl_a_nxt;
  logic [7:0]             ph_b_r, ph_b_nxt;
  logic [7:0]             pl_b_r, pl_b_nxt;
  logic [7:0]             rdata_r, rdata_nxt;
  logic                   brdata_r, brdata_nxt;
  logic [CIH_NUM_SRC-1:0] pending_r, pending_nxt;
  logic [3:0]             in_service_r, in_service_nxt;
  logic                   req_r, req_nxt;
  logic [CIH_IDX_W-1:0]   win_idx_r, win_idx_nxt;
  logic [1:0]             win_lvl_r, win_lvl_nxt;

  logic [CIH_NUM_SRC-1:0] pin_set;
  logic [CIH_NUM_SRC-1:0] hw_clear_ok;
  logic [CIH_NUM_SRC-1:0] grant_mask;
  logic [CIH_NUM_SRC-1:0] enable_vec;
  logic [CIH_NUM_SRC-1:0] prio_hi;
  logic [CIH_NUM_SRC-1:0] prio_lo;
  logic                   ev_ext0, ev_ext1, ev_key;
  logic                   grant;
  logic [7:0]             bit_byte;

  // ************************************************************
  // external inputs
  // ************************************************************
  cih_pin_detect u_ext0 (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .active_i    (~ext_request_zero_n_i),
    .edge_mode_i (ext_edge_mode_i[0]),
    .event_o     (ev_ext0)
  );

  cih_pin_detect u_ext1 (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .active_i    (~ext_request_one_n_i),
    .edge_mode_i (ext_edge_mode_i[1]),
    .event_o     (ev_ext1)
  );

  // keypad line is always taken on its onset
  cih_pin_detect u_key (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .active_i    (keypad_request_in_i),
    .edge_mode_i (1'b1),
    .event_o     (ev_key)
  );

  // pin events land at their fixed source slots
  always_comb begin
    pin_set                 = '0;
    pin_set[CIH_SRC_EXT0]   = ev_ext0;
    pin_set[CIH_SRC_EXT1]   = ev_ext1;
    pin_set[CIH_SRC_KEYPAD] = ev_key;
    // a level-mode pin is cleared by software only, never on vectoring
    hw_clear_ok               = '1;
    hw_clear_ok[CIH_SRC_EXT0] = ext_edge_mode_i[0];
    hw_clear_ok[CIH_SRC_EXT1] = ext_edge_mode_i[1];
  end

  // group a covers sources 0..6, group b sources 7..14
  assign enable_vec = {en_b_r, en_a_r[6:0]};
  assign prio_hi    = {ph_b_r, ph_a_r};
  assign prio_lo    = {pl_b_r, pl_a_r};

  // ************************************************************
  // register file
  // ************************************************************
  assign bit_byte = {bit_addr_i[7:3], 3'b000};

  // byte writes first, then a bit write patches one bit of the result
  always_comb begin
    en_a_nxt   = en_a_r;
    en_b_nxt   = en_b_r;
    ph_a_nxt   = ph_a_r;
    pl_a_nxt   = pl_a_r;
    ph_b_nxt   = ph_b_r;
    pl_b_nxt   = pl_b_r;
    rdata_nxt  = rdata_r;
    brdata_nxt = brdata_r;
    if (sfr_wr_i) begin
      unique case (sfr_addr_i)
        CIH_OFS_EN_A: en_a_nxt = sfr_wdata_i;
        CIH_OFS_EN_B: en_b_nxt = sfr_wdata_i;
        CIH_OFS_PH_A: ph_a_nxt = sfr_wdata_i[6:0];
        CIH_OFS_PL_A: pl_a_nxt = sfr_wdata_i[6:0];
        CIH_OFS_PH_B: ph_b_nxt = sfr_wdata_i;
        CIH_OFS_PL_B: pl_b_nxt = sfr_wdata_i;
        default: ;
      endcase
    end
    // only the 0/8 registers answer bit access; bit 7 of low-a is reserved
    if (bit_wr_i) begin
      if (bit_byte == CIH_OFS_EN_A) begin
        en_a_nxt[bit_addr_i[2:0]] = bit_wdata_i;
      end else if (bit_byte == CIH_OFS_PL_A && bit_addr_i[2:0] != 3'd7) begin
        pl_a_nxt[bit_addr_i[2:0]] = bit_wdata_i;
      end
    end
    if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        CIH_OFS_EN_A: rdata_nxt = en_a_r;
        CIH_OFS_EN_B: rdata_nxt = en_b_r;
        CIH_OFS_PH_A: rdata_nxt = {1'b0, ph_a_r};
        CIH_OFS_PL_A: rdata_nxt = {1'b0, pl_a_r};
        CIH_OFS_PH_B: rdata_nxt = ph_b_r;
        CIH_OFS_PL_B: rdata_nxt = pl_b_r;
        default:      rdata_nxt = CIH_RD_UNMAPPED;
      endcase
    end
    if (bit_rd_i) begin
      if (bit_byte == CIH_OFS_EN_A) begin
        brdata_nxt = en_a_r[bit_addr_i[2:0]];
      end else if (bit_byte == CIH_OFS_PL_A && bit_addr_i[2:0] != 3'd7) begin
        brdata_nxt = pl_a_r[bit_addr_i[2:0]];
      end else begin
        brdata_nxt = 1'b0;
      end
    end
  end

  // ************************************************************
  // pending flags, arbitration, in-service levels
  // ************************************************************
  assign grant = req_r & service_ack_i;

  always_comb begin
    logic [1:0]           best_lvl;
    logic [1:0]           cur_lvl;
    logic [1:0]           lvl;
    logic [CIH_IDX_W-1:0] best_idx;
    logic                 found;
    best_lvl       = 2'd0;
    cur_lvl        = 2'd0;
    lvl            = 2'd0;
    best_idx       = '0;
    found          = 1'b0;
    grant_mask     = '0;
    if (grant) begin
      grant_mask[win_idx_r] = hw_clear_ok[win_idx_r];
    end
    // set wins over both software and vectoring clears
    pending_nxt = (pending_r & ~flag_clear_i & ~grant_mask)
                | periph_event_i | pin_set;
    // scan downward so that on a tie the lowest index is kept
    for (int i = CIH_NUM_SRC - 1; i >= 0; i--) begin
      lvl = {prio_hi[i], prio_lo[i]};
      if (pending_r[i] && enable_vec[i] && en_a_r[CIH_BIT_GLOBAL]) begin
        if (!found || lvl >= best_lvl) begin
          best_lvl = lvl;
          best_idx = CIH_IDX_W'(i);
          found    = 1'b1;
        end
      end
    end
    for (int j = 0; j < 4; j++) begin
      if (in_service_r[j]) begin
        cur_lvl = 2'(j);
      end
    end
    // one cycle of silence after a grant lets the new state settle
    req_nxt     = found && !grant &&
                  (in_service_r == 4'd0 || best_lvl > cur_lvl);
    win_idx_nxt = best_idx;
    win_lvl_nxt = best_lvl;
    in_service_nxt = in_service_r;
    if (service_return_instr_i && in_service_r != 4'd0) begin
      in_service_nxt[cur_lvl] = 1'b0;
    end
    if (grant) begin
      in_service_nxt[win_lvl_r] = 1'b1;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_a_r       <= CIH_RST_REG;
      en_b_r       <= CIH_RST_REG;
      ph_a_r       <= CIH_RST_REG[6:0];
      pl_a_r       <= CIH_RST_REG[6:0];
      ph_b_r       <= CIH_RST_REG;
      pl_b_r       <= CIH_RST_REG;
      rdata_r      <= CIH_RD_UNMAPPED;
      brdata_r     <= 1'b0;
      pending_r    <= '0;
      in_service_r <= 4'd0;
      req_r        <= 1'b0;
      win_idx_r    <= '0;
      win_lvl_r    <= 2'd0;
    end else begin
      en_a_r       <= en_a_nxt;
      en_b_r       <= en_b_nxt;
      ph_a_r       <= ph_a_nxt;
      pl_a_r       <= pl_a_nxt;
      ph_b_r       <= ph_b_nxt;
      pl_b_r       <= pl_b_nxt;
      rdata_r      <= rdata_nxt;
      brdata_r     <= brdata_nxt;
      pending_r    <= pending_nxt;
      in_service_r <= in_service_nxt;
      req_r        <= req_nxt;
      win_idx_r    <= win_idx_nxt;
      win_lvl_r    <= win_lvl_nxt;
    end
  end

  // outputs
  assign sfr_rdata_o      = rdata_r;
  assign bit_rdata_o      = brdata_r;
  assign pending_o        = pending_r;
  assign service_req_o    = req_r;
  assign service_level_o  = win_lvl_r;
  assign service_vector_o = CIH_VEC_BASE
                          + 16'({win_idx_r, 3'b000});

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence ack_s;
    service_req_o && service_ack_i;
  endsequence

  event_capture_a : assert property ((periph_event_i != '0) |=>
    ((pending_r & $past(periph_event_i)) == $past(periph_event_i)))
    else $error("peripheral event not captured");

  pending_hold_a : assert property (1 |=>
    (($past(pending_r) & ~$past(flag_clear_i) & ~$past(grant_mask) & ~pending_r) == '0))
    else $error("pending flag lost without clear");

  global_gate_a : assert property (!en_a_r[CIH_BIT_GLOBAL] |=> !service_req_o)
    else $error("request while global enable clear");

  strict_preempt_a : assert property ((service_req_o && in_service_r != 4'd0) |->
    (in_service_r >> service_level_o) == 4'd0)
    else $error("preemption by equal or lower level");

  vector_step_a : assert property (service_req_o |->
    service_vector_o == CIH_VEC_BASE + 16'(win_idx_r) * 16'd8)
    else $error("vector does not match winner");

  ack_drop_a : assert property (ack_s |=> !service_req_o)
    else $error("request held after grant");

  ack_level_a : assert property (ack_s ##1 !service_return_instr_i[*1] |=>
    in_service_r[$past(service_level_o, 2)])
    else $error("granted level not marked in service");

  return_clear_a : assert property ((service_return_instr_i && !grant &&
    in_service_r != 4'd0) |=>
    $countones(in_service_r) == $countones($past(in_service_r)) - 1)
    else $error("return did not clear a level");

  bit_write_a : assert property ((bit_wr_i && !sfr_wr_i && bit_byte == CIH_OFS_EN_A) |=>
    en_a_r[$past(bit_addr_i[2:0])] == $past(bit_wdata_i))
    else $error("bit write to first enable lost");

endmodule
`default_nettype wire

// ==== tb/cih_core_model.sv ====
// execution unit model: finishes its instruction, grants, loads vector, returns
`timescale 1ns/1ps
`default_nettype none

module cih_core_model (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // handler side
  input  wire logic        service_req_i,
  input  wire logic [15:0] service_vector_i,
  output logic             service_ack_o,
  output logic             service_return_instr_o,
  // bench control
  input  wire logic [3:0]  finish_cycles_i,
  input  wire logic        return_cmd_i,
  output logic      [15:0] pc_o
);
  logic [3:0] wait_r;

  // grant only once the running instruction has used up its cycles
  always @(negedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_r <= 4'h0;
      service_ack_o <= 1'b0;
      service_return_instr_o <= 1'b0;
      pc_o <= 16'h0000;
    end else begin
      service_ack_o <= 1'b0;
      service_return_instr_o <= return_cmd_i;
      if (service_req_i && !service_ack_o) begin
        if (wait_r >= finish_cycles_i) begin
          service_ack_o <= 1'b1;
          pc_o <= service_vector_i;
          wait_r <= 4'h0;
        end else begin
          wait_r <= wait_r + 4'h1;
        end
      end else begin
        wait_r <= 4'h0;
      end
    end
  end
endmodule

`default_nettype wire

// ==== tb/core_interrupt_handler_bench.sv ====
// self-checking bench for the core interrupt handler
`timescale 1ns/1ps
`default_nettype none

module core_interrupt_handler_bench;
  import cih_pkg::*;

  logic        ref_clk, reset_n, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, bit_rdata;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, bit_addr;
  logic [14:0] periph_event, flag_clear, pending;
  logic        pin0_n, pin1_n, keypad, req, ack, ret, ret_cmd;
  logic [1:0]  edge_mode, level;
  logic [15:0] vector, pc;
  logic [3:0]  finish;
  int          bad_count = 0;
  int          check_count = 0;
  int          cycles = 0;

  cih_handler i_cih_handler (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
    .sfr_addr_i(sfr_addr), .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd), .sfr_wdata_i(sfr_wdata),
    .sfr_rdata_o(sfr_rdata), .bit_addr_i(bit_addr), .bit_wr_i(bit_wr), .bit_rd_i(bit_rd),
    .bit_wdata_i(bit_wdata), .bit_rdata_o(bit_rdata), .periph_event_i(periph_event),
    .flag_clear_i(flag_clear), .ext_request_zero_n_i(pin0_n), .ext_request_one_n_i(pin1_n),
    .ext_edge_mode_i(edge_mode), .keypad_request_in_i(keypad), .service_req_o(req),
    .service_vector_o(vector), .service_level_o(level), .service_ack_i(ack),
    .service_return_instr_i(ret), .pending_o(pending));

  cih_core_model i_cih_core_model (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
    .service_req_i(req), .service_vector_i(vector), .service_ack_o(ack),
    .service_return_instr_o(ret), .finish_cycles_i(finish), .return_cmd_i(ret_cmd),
    .pc_o(pc));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] vec(input int k);
    return CIH_VEC_BASE + 16'(k << CIH_VEC_SHIFT);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask

  // read data is registered, so look one cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    @(negedge ref_clk);
    check({8'h00, sfr_rdata}, {8'h00, exp});
  endtask

  task automatic pulse(input logic [14:0] m);
    @(negedge ref_clk);
    periph_event = m;
    @(negedge ref_clk);
    periph_event = '0;
  endtask

  // bounded wait, then judge the winner shown to the core
  task automatic wait_req(input logic [15:0] v, input logic [1:0] l);
    int n;
    n = 0;
    while (req !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    check({15'h0000, req}, 16'h0001);
    check(vector, v);
    check({14'h0000, level}, {14'h0000, l});
  endtask

  task automatic no_req(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      check({15'h0000, req}, 16'h0000);
    end
  endtask

  task automatic grant(input logic [15:0] v);
    repeat (6) @(negedge ref_clk);
    check(pc, v);
  endtask

  task automatic ret_once();
    @(negedge ref_clk);
    ret_cmd = 1'b1;
    @(negedge ref_clk);
    ret_cmd = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs();
    logic [7:0] regs [6];
    regs = '{CIH_OFS_EN_A, CIH_OFS_EN_B, CIH_OFS_PL_B, CIH_OFS_PH_B, CIH_OFS_PH_A, CIH_OFS_PL_A};
    foreach (regs[i]) rd_chk(regs[i], CIH_RST_REG);
    rd_chk(8'h90, CIH_RD_UNMAPPED);
    wr(CIH_OFS_PL_B, 8'h5a);
    rd_chk(CIH_OFS_PL_B, 8'h5a);
    wr(CIH_OFS_PH_A, 8'hff);
    rd_chk(CIH_OFS_PH_A, 8'h7f);
    // bit write to the first enable register, bit 7
    @(negedge ref_clk);
    bit_addr = CIH_OFS_EN_A | 8'h07;
    bit_wdata = 1'b1;
    bit_wr = 1'b1;
    @(negedge ref_clk);
    bit_wr = 1'b0;
    rd_chk(CIH_OFS_EN_A, 8'h80);
    @(negedge ref_clk);
    bit_addr = CIH_OFS_PL_A | 8'h04;
    bit_wdata = 1'b1;
    bit_wr = 1'b1;
    @(negedge ref_clk);
    bit_wr = 1'b0;
    bit_rd = 1'b1;
    @(negedge ref_clk);
    bit_rd = 1'b0;
    @(negedge ref_clk);
    check({15'h0000, bit_rdata}, 16'h0001);
    rd_chk(CIH_OFS_PL_A, 8'h10);
    foreach (regs[i]) wr(regs[i], 8'h00);
  endtask

  task automatic t_enable();
    pulse(15'h0008);
    check({1'b0, pending}, 16'h0008);
    no_req(6);
    wr(CIH_OFS_EN_A, 8'h08);
    no_req(6);
    wr(CIH_OFS_EN_A, 8'h88);
    wait_req(vec(3), 2'd0);
    grant(vec(3));
    check({1'b0, pending}, 16'h0000);
    ret_once();
  endtask

  // equal levels: lowest index first, the other waits for the return
  task automatic t_tie();
    wr(CIH_OFS_EN_A, 8'ha2);
    pulse(15'h0022);
    wait_req(vec(1), 2'd0);
    grant(vec(1));
    no_req(8);
    ret_once();
    wait_req(vec(5), 2'd0);
    grant(vec(5));
    ret_once();
  endtask

  task automatic t_level();
    wr(CIH_OFS_PH_A, 8'h20);
    wr(CIH_OFS_PL_A, 8'h02);
    pulse(15'h0022);
    wait_req(vec(5), 2'd2);
    grant(vec(5));
    no_req(6);
    wr(CIH_OFS_PH_A, 8'h22);
    wait_req(vec(1), 2'd3);
    grant(vec(1));
    ret_once();
    ret_once();
  endtask

  // edge pin stays clear while held low, level pin keeps setting
  task automatic t_pins();
    wr(CIH_OFS_EN_A, 8'h00);
    edge_mode = 2'b01;
    pin0_n = 1'b0;
    pin1_n = 1'b0;
    keypad = 1'b1;
    repeat (3) @(negedge ref_clk);
    check({1'b0, pending}, 16'h0805);
    flag_clear = 15'h0805;
    @(negedge ref_clk);
    flag_clear = '0;
    repeat (3) @(negedge ref_clk);
    check({1'b0, pending}, 16'h0004);
  endtask

  // ************************************************************
  // clock, sequence and timeout
  // ************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    reset_n = 1'b0;
    {sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, keypad, ret_cmd} = '0;
    {sfr_addr, sfr_wdata, bit_addr} = '0;
    {periph_event, flag_clear} = '0;
    {pin0_n, pin1_n} = 2'b11;
    edge_mode = 2'b00;
    finish = 4'h3;
    repeat (20) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    t_regs();
    t_enable();
    t_tie();
    t_level();
    t_pins();
    final_report();
  end

  // a hang counts as a mismatch
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      final_report();
    end
  end
endmodule

`default_nettype wire
